// ---- lec_params.svh ----
// Register map, field positions, reset values and timing constants of the exposure controller.
`ifndef LEC_PARAMS_SVH
`define LEC_PARAMS_SVH

`define LEC_ADDR_CTRL 8'h00
`define LEC_ADDR_RAW 8'h04
`define LEC_ADDR_BASE 8'h08
`define LEC_ADDR_ABS 8'h0c
`define LEC_ADDR_PERIOD 8'h10
`define LEC_ADDR_LINES 8'h14
`define LEC_ADDR_CMD 8'h18
`define LEC_ADDR_STATUS 8'h1c

`define LEC_CTRL_LINE_TRIG 0
`define LEC_CTRL_MODE_LO 1
`define LEC_CTRL_MODE_HI 2
`define LEC_CTRL_FALLING 3
`define LEC_CTRL_ACQ_TRIG 4
`define LEC_CTRL_FRAME_TRIG 5
`define LEC_CTRL_RATE_EN 6
`define LEC_CTRL_SINGLE 7

`define LEC_CMD_START 0
`define LEC_CMD_STOP 1

`define LEC_RST_CTRL 8'h00
`define LEC_RST_RAW 12'h064
`define LEC_RST_BASE 16'h000a
`define LEC_RST_PERIOD 32'h0000_30d4
`define LEC_RST_LINES 16'h0400

`define LEC_RAW_MIN 12'h001
`define LEC_RAW_MAX 12'hfff

`define LEC_RESP_OKAY 2'h0
`define LEC_RESP_SLVERR 2'h2

`define LEC_CLK_MHZ 125
`define LEC_TENTHS_PER_US 10
`define LEC_TICK_INC 8'(`LEC_TENTHS_PER_US)
`define LEC_TICK_MOD 8'(`LEC_CLK_MHZ)

`define LEC_EXP_MIN_TENTHS 13
`define LEC_EXP_MAX_US 10000
`define LEC_EXP_MAX_TENTHS (`LEC_EXP_MAX_US * `LEC_TENTHS_PER_US)

`endif

// ---- lec_pkg.sv ----
// Types shared by the exposure controller modules.
`default_nettype none
package lec_pkg;

  typedef enum logic [1:0] {
    LEC_ACQ_IDLE = 2'b00,
    LEC_ACQ_WAIT_START = 2'b01,
    LEC_ACQ_WAIT_FRAME = 2'b10,
    LEC_ACQ_LINES = 2'b11
  } lec_acq_state_t;

  typedef enum logic [1:0] {
    LEC_EXP_TIMED = 2'b00,
    LEC_EXP_WIDTH = 2'b01,
    LEC_EXP_OFF = 2'b10,
    LEC_EXP_RSVD = 2'b11
  } lec_exp_mode_t;

endpackage : lec_pkg

`default_nettype wire

// ---- lec_tick_div.sv ----
// Fractional divider that emits one pulse per tenth of a microsecond.
`timescale 1ns/1ps
`default_nettype none

module lec_tick_div
  import lec_pkg::*;
#(
  parameter logic [7:0] INC = 8'h0a,
  parameter logic [7:0] MOD = 8'h7d
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Tick output
  output logic tick
);

  // The clock period is not a whole fraction of 0.1 us, so ticks alternate
  // between 12 and 13 cycles and average out exactly.
  logic [7:0] acc_q;
  logic tick_q;
  wire [8:0] sum = {1'b0, acc_q} + {1'b0, INC};
  wire wrap = sum >= {1'b0, MOD};
  wire [8:0] diff = sum - {1'b0, MOD};
  wire [7:0] acc_d = wrap ? diff[7:0] : sum[7:0];

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      tick_q <= wrap;
    end
  end

  assign tick = tick_q;

endmodule : lec_tick_div

`default_nettype wire

// ---- lec_line_exposure.sv ----
// Line exposure controller with AXI4-Lite registers and free-run acquisition sequencing.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lec_params.svh"

// Functional notes
// - Raw exposure length is the multiplier times the time base.
// - Multiplier writes outside 1 to 4095 are not taken.
// - The time base resets to 1.0 us and is set in 0.1 us steps.
// - The absolute exposure is given in 0.1 us units, whatever the time base.
// - An absolute value off the time-base grid is rounded to the nearest multiple.
// - The absolute value read back always follows the current multiplier and base.
// - Parameter-timed exposure is clamped between the minimum and 10000 us.
// - In width and off modes the trigger sets exposure, with a minimum and no maximum.
// - With all triggers disabled the block makes its own triggers and runs free.
// - Free-run lines are paced by the line period, or run flat out when it is disabled.
// - In single-frame mode each start command yields exactly one frame.
// - Width exposure runs from the active trigger edge to the opposite edge.
module lec_line_exposure
  import lec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger inputs
  input wire logic acq_trig,
  input wire logic frame_trig,
  input wire logic line_trig,
  // Acquisition outputs
  output logic exposure,
  output logic line_start,
  output logic frame_done,
  output logic acq_active
);

  localparam logic [27:0] EXP_MIN = 28'(`LEC_EXP_MIN_TENTHS);
  localparam logic [27:0] EXP_MAX = 28'(`LEC_EXP_MAX_TENTHS);

  // Register state.
  logic [7:0] ctrl_q;
  logic [11:0] raw_q;
  logic [15:0] base_q;
  logic [31:0] period_q;
  logic [15:0] lines_q;

  // Bus state.
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // Sequencer and exposure state.
  lec_acq_state_t acq_q, acq_d;
  logic exposing_q;
  logic [27:0] elapsed_q;
  logic [31:0] period_cnt_q;
  logic [15:0] line_cnt_q;
  logic line_prev_q, acq_prev_q, frame_prev_q;
  logic start_cmd_q, stop_cmd_q;
  logic line_start_q, frame_done_q;
  logic acq_active_q;
  logic tick;

  lec_tick_div #(
    .INC(`LEC_TICK_INC),
    .MOD(`LEC_TICK_MOD)
  ) u_tick (
    .clock(clock),
    .arst_n(arst_n),
    .tick(tick)
  );

  // Exposure length from the raw settings, in tenths of a microsecond.
  wire [27:0] exp_prod = {16'h0000, raw_q} * {12'h000, base_q};
  wire [31:0] abs_word = {4'h0, exp_prod};
  wire [31:0] status_word = {line_cnt_q, 13'h0000, acq_q, exposing_q};

  function automatic logic [31:0] reg_word(input logic [7:0] a, input logic [31:0] ab,
                                           input logic [31:0] st, input logic [7:0] c,
                                           input logic [11:0] r, input logic [15:0] b,
                                           input logic [31:0] p, input logic [15:0] l);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `LEC_ADDR_CTRL: v = {24'h00_0000, c};
      `LEC_ADDR_RAW: v = {20'h0_0000, r};
      `LEC_ADDR_BASE: v = {16'h0000, b};
      `LEC_ADDR_ABS: v = ab;
      `LEC_ADDR_PERIOD: v = p;
      `LEC_ADDR_LINES: v = {16'h0000, l};
      `LEC_ADDR_STATUS: v = st;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_word

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `LEC_ADDR_STATUS);
  endfunction : mapped

  // Write decode: merge the byte lanes into the current word.
  wire wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  wire wr_ok = mapped(awaddr_q);
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wr_old = reg_word(awaddr_q, abs_word, status_word, ctrl_q, raw_q, base_q,
                                period_q, lines_q);
  wire [31:0] wv = (wr_old & ~wmask) | (wdata_q & wmask);
  wire wr_en = wr_fire & wr_ok;
  wire we_ctrl = wr_en & (awaddr_q == `LEC_ADDR_CTRL);
  wire we_raw = wr_en & (awaddr_q == `LEC_ADDR_RAW);
  wire we_base = wr_en & (awaddr_q == `LEC_ADDR_BASE);
  wire we_abs = wr_en & (awaddr_q == `LEC_ADDR_ABS);
  wire we_period = wr_en & (awaddr_q == `LEC_ADDR_PERIOD);
  wire we_lines = wr_en & (awaddr_q == `LEC_ADDR_LINES);
  wire we_cmd = wr_en & (awaddr_q == `LEC_ADDR_CMD);
  wire raw_legal = (wv[31:12] == 20'h0_0000) && (wv[11:0] >= `LEC_RAW_MIN);
  wire base_legal = (wv[31:16] == 16'h0000) && (wv[15:0] != 16'h0000);

  // Absolute writes are rounded to the nearest whole number of time-base steps.
  // The divider is combinational; it sits only on the register write path.
  wire [32:0] abs_num = {1'b0, wv} + {18'h0_0000, base_q[15:1]};
  wire [32:0] abs_quot = abs_num / {17'h0_0000, base_q};
  wire [11:0] abs_raw = (abs_quot == 33'h0_0000_0000) ? `LEC_RAW_MIN :
                        (abs_quot > {21'h00_0000, `LEC_RAW_MAX}) ? `LEC_RAW_MAX :
                        abs_quot[11:0];

  wire [31:0] rd_word = reg_word(s_axi_araddr, abs_word, status_word, ctrl_q, raw_q, base_q,
                                 period_q, lines_q);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `LEC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `LEC_RESP_OKAY : `LEC_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `LEC_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= mapped(s_axi_araddr) ? `LEC_RESP_OKAY : `LEC_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= `LEC_RST_CTRL;
      raw_q <= `LEC_RST_RAW;
      base_q <= `LEC_RST_BASE;
      period_q <= `LEC_RST_PERIOD;
      lines_q <= `LEC_RST_LINES;
      start_cmd_q <= 1'b0;
      stop_cmd_q <= 1'b0;
    end
    else
    begin
      if (we_ctrl)
        ctrl_q <= wv[7:0];
      if (we_raw && raw_legal)
        raw_q <= wv[11:0];
      else if (we_abs)
        raw_q <= abs_raw;
      if (we_base && base_legal)
        base_q <= wv[15:0];
      if (we_period)
        period_q <= wv;
      if (we_lines && (wv[15:0] != 16'h0000))
        lines_q <= wv[15:0];
      start_cmd_q <= we_cmd & wv[`LEC_CMD_START];
      stop_cmd_q <= we_cmd & wv[`LEC_CMD_STOP];
    end
  end

  // Control fields.
  wire line_trig_en = ctrl_q[`LEC_CTRL_LINE_TRIG];
  wire falling = ctrl_q[`LEC_CTRL_FALLING];
  wire acq_trig_en = ctrl_q[`LEC_CTRL_ACQ_TRIG];
  wire frame_trig_en = ctrl_q[`LEC_CTRL_FRAME_TRIG];
  wire rate_en = ctrl_q[`LEC_CTRL_RATE_EN];
  wire single = ctrl_q[`LEC_CTRL_SINGLE];
  wire [1:0] mode_bits = ctrl_q[`LEC_CTRL_MODE_HI:`LEC_CTRL_MODE_LO];
  // Without a line trigger the parameters always time exposure.
  wire lec_exp_mode_t mode = !line_trig_en ? LEC_EXP_TIMED : lec_exp_mode_t'(mode_bits);
  wire mode_width = (mode == LEC_EXP_WIDTH);
  wire mode_off = (mode == LEC_EXP_OFF);
  wire mode_timed = !mode_width && !mode_off;

  // A product below the minimum is lifted to it; software must still avoid it.
  wire [27:0] target = (exp_prod < EXP_MIN) ? EXP_MIN :
                       (exp_prod > EXP_MAX) ? EXP_MAX : exp_prod;

  // Trigger edges, with the activation polarity folded into the line trigger.
  wire trig_act = line_trig ^ falling;
  wire trig_act_prev = line_prev_q ^ falling;
  wire act_edge = trig_act & ~trig_act_prev;
  wire acq_rise = acq_trig & ~acq_prev_q;
  wire frame_rise = frame_trig & ~frame_prev_q;

  wire min_met = elapsed_q >= EXP_MIN;
  wire end_timed = mode_timed & (elapsed_q >= target);
  wire end_width = mode_width & ~trig_act & min_met;
  wire end_off = mode_off & act_edge & min_met;
  wire exp_end = exposing_q & (end_timed | end_width | end_off);

  wire in_lines = (acq_q == LEC_ACQ_LINES);
  wire lines_left = line_cnt_q != lines_q;
  wire last_line = line_cnt_q == lines_q;
  wire rate_ok = !rate_en || (period_cnt_q >= period_q);
  wire int_go = !line_trig_en & ~exposing_q & rate_ok;
  // In off mode the edge that ends one line also opens the next.
  wire ext_go = line_trig_en & act_edge & (~exposing_q | end_off);
  wire line_go = in_lines & lines_left & (int_go | ext_go);
  wire frame_end = in_lines & exp_end & last_line;

  always_comb
  begin
    acq_d = acq_q;
    unique case (acq_q)
      LEC_ACQ_IDLE:
        if (start_cmd_q)
          acq_d = LEC_ACQ_WAIT_START;
      LEC_ACQ_WAIT_START:
        if (!acq_trig_en || acq_rise)
          acq_d = LEC_ACQ_WAIT_FRAME;
      LEC_ACQ_WAIT_FRAME:
        if (!frame_trig_en || frame_rise)
          acq_d = LEC_ACQ_LINES;
      LEC_ACQ_LINES:
        if (frame_end)
          acq_d = single ? LEC_ACQ_IDLE : LEC_ACQ_WAIT_FRAME;
    endcase
    if (stop_cmd_q)
      acq_d = LEC_ACQ_IDLE;
  end

  wire frame_open = (acq_q == LEC_ACQ_WAIT_FRAME) && (acq_d == LEC_ACQ_LINES);
  wire [27:0] elapsed_inc = elapsed_q + 28'h000_0001;
  wire [31:0] period_inc = period_cnt_q + 32'h0000_0001;
  wire [15:0] line_inc = line_cnt_q + 16'h0001;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acq_q <= LEC_ACQ_IDLE;
      exposing_q <= 1'b0;
      elapsed_q <= 28'h000_0000;
      period_cnt_q <= 32'h0000_0000;
      line_cnt_q <= 16'h0000;
      line_prev_q <= 1'b0;
      acq_prev_q <= 1'b0;
      frame_prev_q <= 1'b0;
      line_start_q <= 1'b0;
      frame_done_q <= 1'b0;
      acq_active_q <= 1'b0;
    end
    else
    begin
      acq_q <= acq_d;
      acq_active_q <= (acq_d != LEC_ACQ_IDLE);
      line_prev_q <= line_trig;
      acq_prev_q <= acq_trig;
      frame_prev_q <= frame_trig;
      line_start_q <= line_go;
      frame_done_q <= frame_end;
      if (line_go)
      begin
        exposing_q <= 1'b1;
        elapsed_q <= 28'h000_0000;
      end
      else if (exp_end)
        exposing_q <= 1'b0;
      else if (exposing_q && tick && (elapsed_q != 28'hfff_ffff))
        elapsed_q <= elapsed_inc;
      if (line_go)
        period_cnt_q <= 32'h0000_0001;
      else if (period_cnt_q != 32'hffff_ffff)
        period_cnt_q <= period_inc;
      if (frame_open)
        line_cnt_q <= 16'h0000;
      else if (line_go)
        line_cnt_q <= line_inc;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign exposure = exposing_q;
  assign line_start = line_start_q;
  assign frame_done = frame_done_q;
  assign acq_active = acq_active_q;

endmodule : lec_line_exposure

`default_nettype wire

// ---- lec_exp_asserts.sv ----
// Concurrent checks on the ports of the line exposure controller.
`timescale 1ns/1ps
`default_nettype none

module lec_exp_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Acquisition outputs
  input wire logic exposure,
  input wire logic line_start,
  input wire logic frame_done,
  input wire logic acq_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Thirteen ticks span at least 150 cycles, whichever tick phase the line starts on.
  logic [20:0] run_q;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      run_q <= 21'h0;
    else if (exposure)
      run_q <= run_q + 21'h1;
    else
      run_q <= 21'h0;
  end

  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before bready");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before rready");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("no write response after address and data");
  property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_after: assert property (p_r_after)
    else $error("no read data after read address");
  property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_busy: assert property (p_w_busy)
    else $error("second write accepted while a response is pending");
  property p_exp_ls; $rose(exposure) |-> line_start; endproperty
  a_exp_ls: assert property (p_exp_ls)
    else $error("no line start pulse after exposure began");
  property p_ls_pulse; line_start |=> !line_start; endproperty
  a_ls_pulse: assert property (p_ls_pulse)
    else $error("line start longer than one cycle");
  property p_fd_pulse; frame_done |=> !frame_done; endproperty
  a_fd_pulse: assert property (p_fd_pulse)
    else $error("frame done longer than one cycle");
  property p_min_exp; $fell(exposure) |-> run_q >= 21'h96; endproperty
  a_min_exp: assert property (p_min_exp)
    else $error("exposure shorter than the minimum");
  property p_exp_acq; $rose(exposure) |-> acq_active; endproperty
  a_exp_acq: assert property (p_exp_acq)
    else $error("exposure began while acquisition idle");

  c_frame: cover property (frame_done);
  c_line: cover property (line_start);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : lec_exp_chk

bind lec_line_exposure lec_exp_chk u_chk (.clock(clock), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .exposure(exposure),
  .line_start(line_start), .frame_done(frame_done), .acq_active(acq_active));

`default_nettype wire

// ---- lec_tb.sv ----
// Self-checking bench for the line exposure controller.
`timescale 1ns/1ps
`default_nettype none
`include "lec_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end

module tb;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, acq_trig = 1'b0, frame_trig = 1'b0, line_trig = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic exposure, line_start, frame_done, acq_active, exp_d = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int failures = 0, cmp_count = 0, cyc = 0, ls_n, fd_n, rise_t, fall_t, len, gap, idle;

  always #4 clock = ~clock;

  lec_line_exposure dut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .acq_trig(acq_trig), .frame_trig(frame_trig),
    .line_trig(line_trig), .exposure(exposure), .line_start(line_start),
    .frame_done(frame_done), .acq_active(acq_active));

  task close_out;
    $display("mismatches %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Records exposure length, start-to-start spacing and dead time between lines.
  always @(posedge clock)
  begin
    cyc++;
    if (line_start) ls_n++;
    if (frame_done) fd_n++;
    if (exposure && !exp_d)
    begin
      gap = cyc - rise_t;
      idle = cyc - fall_t;
      rise_t = cyc;
    end
    if (!exposure && exp_d)
    begin
      len = cyc - rise_t;
      fall_t = cyc;
    end
    exp_d = exposure;
    if (cyc == 20000)
    begin
      failures++;
      close_out();
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, e)
  endtask : rd

  task start(input logic [31:0] ctrl, input logic [31:0] lines);
    wr(`LEC_ADDR_CTRL, ctrl);
    wr(`LEC_ADDR_LINES, lines);
    ls_n = 0;
    fd_n = 0;
    wr(`LEC_ADDR_CMD, 32'h1);
  endtask : start

  task trig(input int n);
    @(posedge clock);
    line_trig <= ~line_trig;
    repeat (n) @(posedge clock);
    line_trig <= ~line_trig;
  endtask : trig

  task wait_fd;
    while (fd_n == 0) @(posedge clock);
    repeat (20) @(posedge clock);
  endtask : wait_fd

  task t_regs;
    rd(`LEC_ADDR_BASE, 32'ha);
    rd(`LEC_ADDR_ABS, 32'h3e8);
    wr(`LEC_ADDR_RAW, 32'hfff);
    wr(`LEC_ADDR_RAW, 32'h0);
    wr(`LEC_ADDR_RAW, 32'h1000);
    rd(`LEC_ADDR_RAW, 32'hfff);
    wr(`LEC_ADDR_BASE, 32'h0);
    rd(`LEC_ADDR_BASE, 32'ha);
    wr(`LEC_ADDR_BASE, 32'h19);
    wr(`LEC_ADDR_RAW, 32'h3);
    rd(`LEC_ADDR_ABS, 32'h4b);
    wr(`LEC_ADDR_BASE, 32'ha);
    wr(`LEC_ADDR_ABS, 32'h22);
    rd(`LEC_ADDR_RAW, 32'h3);
    wr(`LEC_ADDR_ABS, 32'h24);
    rd(`LEC_ADDR_ABS, 32'h28);
    wr(8'h02, 32'h1);
    `CHK(resp, `LEC_RESP_SLVERR)
    rd(8'h24, 32'h0);
    `CHK(resp, `LEC_RESP_SLVERR)
  endtask : t_regs

  task t_timed;
    wr(`LEC_ADDR_RAW, 32'h2);
    wr(`LEC_ADDR_PERIOD, 32'h3e8);
    start(32'hc0, 32'h2);
    while (ls_n < 2) @(posedge clock);
    `CHK(gap >= 1000 && gap <= 1001, 1'b1)
    wait_fd;
    `CHK(len >= 239 && len <= 252, 1'b1)
    repeat (1200) @(posedge clock);
    `CHK({ls_n == 2, fd_n == 1, acq_active}, 3'b110)
  endtask : t_timed

  task t_fast;
    wr(`LEC_ADDR_RAW, 32'h1);
    wr(`LEC_ADDR_BASE, 32'hd);
    start(32'h80, 32'h3);
    wait_fd;
    `CHK(len >= 150 && len <= 190, 1'b1)
    `CHK(idle <= 3, 1'b1)
    `CHK(ls_n, 3)
  endtask : t_fast

  task t_width;
    start(32'h93, 32'h2);
    trig(20);
    repeat (20) @(posedge clock);
    `CHK(ls_n, 0)
    acq_trig <= 1'b1;
    repeat (4) @(posedge clock);
    acq_trig <= 1'b0;
    repeat (10) @(posedge clock);
    trig(400);
    repeat (20) @(posedge clock);
    `CHK(len >= 396 && len <= 404, 1'b1)
    trig(50);
    wait_fd;
    `CHK(len >= 150 && len <= 190, 1'b1)
  endtask : t_width

  task t_fall;
    line_trig <= 1'b1;
    start(32'hab, 32'h1);
    // The sequencer needs two cycles to reach the frame wait after the start command.
    repeat (4) @(posedge clock);
    frame_trig <= 1'b1;
    repeat (4) @(posedge clock);
    frame_trig <= 1'b0;
    repeat (10) @(posedge clock);
    trig(300);
    wait_fd;
    `CHK(len >= 296 && len <= 304, 1'b1)
    `CHK(acq_active, 1'b0)
  endtask : t_fall

  // Off mode, continuous frames: an active edge closes one line and opens the next, except at the frame's last line.
  task t_off;
    line_trig <= 1'b0;
    start(32'h5, 32'h2);
    repeat (4) @(posedge clock);
    repeat (3) trig(200);
    `CHK(len >= 400 && len <= 404, 1'b1)
    `CHK({ls_n == 2, fd_n == 1, acq_active}, 3'b111)
    wr(`LEC_ADDR_CMD, 32'h2);
    trig(200);
    `CHK({ls_n == 2, acq_active}, 2'b10)
  endtask : t_off

  initial
  begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_timed();
    t_fast();
    t_width();
    t_fall();
    t_off();
    close_out();
  end
endmodule : tb

`default_nettype wire
